// ===== verilog/irct_defines.vh
// register offsets, field positions, reset values and codes for the counter/timer common control
`ifndef IRCT_DEFINES_VH
`define IRCT_DEFINES_VH
`define IRCT_ADDR_SHARED_CTRL   8'h04
`define IRCT_ADDR_SHORT_CTRL    8'h08
`define IRCT_ADDR_LOAD          8'h0C
`define IRCT_ADDR_CAPTURE       8'h10
`define IRCT_ADDR_STATUS        8'h14
`define IRCT_SC_MODE            7
`define IRCT_SC_SEL             6
`define IRCT_SC_FUNC_HI         5
`define IRCT_SC_FUNC_LO         4
`define IRCT_SC_RISE_FLAG       1
`define IRCT_SC_FALL_FLAG       0
`define IRCT_SHARED_RESET       8'h00
`define IRCT_KC_ENABLE          7
`define IRCT_KC_TIMEOUT_FLAG    5
`define IRCT_KC_CAP_MASK        2
`define IRCT_KC_CNT_MASK        1
`define IRCT_KC_OUT_SEL         0
`define IRCT_SHORT_RESET        8'h00
`define IRCT_LOGIC_AND          2'b00
`define IRCT_LOGIC_OR           2'b01
`define IRCT_LOGIC_NOR          2'b10
`define IRCT_LOGIC_NAND         2'b11
`define IRCT_EDGE_FALL          2'b00
`define IRCT_EDGE_RISE          2'b01
`define IRCT_EDGE_BOTH          2'b10
`define IRCT_COUNT_RELOAD       8'hFF
`define IRCT_LOAD_RESET         8'hFF
`define IRCT_PRESCALE           8'd8
`endif

// ===== verilog/irct_edge_sync.v
// two-flop pin synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
module irct_edge_sync (
    input  wire clk_in,     // core clock
    input  wire rst_in,     // async reset, active high
    input  wire pin_in,     // asynchronous pin
    output wire level_out,  // synchronised level
    output wire rise_out,   // one-cycle pulse on rising edge
    output wire fall_out    // one-cycle pulse on falling edge
);
    reg meta;   // first stage, read only by sync
    reg sync;   // second stage
    reg last;   // previous synchronised level

    // first stage feeds only the second stage to keep metastability contained
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= pin_in;
            sync <= meta;
            last <= sync;
        end
    end

    assign level_out = sync;
    assign rise_out  = sync & ~last;
    assign fall_out  = ~sync & last;
endmodule

// ===== verilog/irct_common_ctrl.v
// common control, capture and timeout logic for the short and long counter/timers
//
// Summary of operation
// R1: capture interrupt when capture mask set
// R2: counter interrupt on short counter timeout
// R3: select bit routes port or counter out
// R4: bit 7 mode, 0 transmit, 1 demod
// R5: transmit bit 6 picks port or combined
// R6: demod bit 6 picks comparator or alternate
// R7: transmit bits 5:4 combine AND/OR/NOR/NAND
// R8: demod bits 5:4 falling/rising/both edges
// R9: capture sets rise or fall status flag
// R10: after capture reload all ones, count down
// R11: zero in demod sets timeout, reload
// R12: interrupt needs flag and mask both set
`timescale 1ns/10ps
`include "irct_defines.vh"
module irct_common_ctrl #(
    parameter PRESCALE = 8      // core clocks per counter tick
) (
    input  wire        clk_in,                // 20 MHz core clock
    input  wire        rst_in,                // async reset, active high
    input  wire        psel_in,               // apb select
    input  wire        penable_in,            // apb access phase
    input  wire        pwrite_in,             // apb direction
    input  wire [7:0]  paddr_in,              // apb byte address
    input  wire [31:0] pwdata_in,             // apb write data
    output wire        pready_out,            // apb ready, always one
    output reg  [31:0] prdata_out,            // apb read data
    output wire        pslverr_out,           // apb error on unmapped address
    input  wire        comparator_input_pin_in, // edge source 0
    input  wire        alternate_input_pin_in,  // edge source 1
    input  wire        port_out_value_in,     // ordinary port value for short pin
    input  wire        shared_port_value_in,  // ordinary port value for shared pin
    input  wire        long_counter_out_in,   // output of the long counter
    output reg         short_counter_out_pin_out, // short counter pin
    output reg         shared_out_pin_out,    // shared output pin
    output reg         irq_out                // interrupt request
);
    reg [7:0] shared_timer_control;  // mode, select, function, edge flags
    reg [7:0] short_counter_control; // enable, timeout flag, masks, out select
    reg [7:0] load_value;            // short counter transmit reload
    reg [7:0] short_counter;         // down counter
    reg       short_counter_out;     // toggling counter waveform
    reg [7:0] rise_capture_byte;     // count captured on rising edge
    reg [7:0] fall_capture_byte;     // count captured on falling edge
    reg [7:0] prescale_count;        // tick divider
    reg       tick;                  // one-cycle counter enable

    wire       cmp_rise, cmp_fall, alt_rise, alt_fall;
    wire       mode_demod = shared_timer_control[`IRCT_SC_MODE];   // see R4
    wire       in_sel     = shared_timer_control[`IRCT_SC_SEL];
    wire [1:0] func       = shared_timer_control[`IRCT_SC_FUNC_HI:`IRCT_SC_FUNC_LO];
    wire       cnt_en     = short_counter_control[`IRCT_KC_ENABLE];

    wire apb_access = psel_in & penable_in;
    wire apb_write  = apb_access & pwrite_in;

    // decode a byte address into a mapped flag
    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `IRCT_ADDR_SHARED_CTRL) | (addr == `IRCT_ADDR_SHORT_CTRL) |
                     (addr == `IRCT_ADDR_LOAD) | (addr == `IRCT_ADDR_CAPTURE) |
                     (addr == `IRCT_ADDR_STATUS);
        end
    endfunction

    assign pready_out  = 1'b1;
    assign pslverr_out = apb_access & ~mapped(paddr_in);

    irct_edge_sync u_cmp (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (comparator_input_pin_in),
        .level_out (),
        .rise_out  (cmp_rise),
        .fall_out  (cmp_fall)
    );

    irct_edge_sync u_alt (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (alternate_input_pin_in),
        .level_out (),
        .rise_out  (alt_rise),
        .fall_out  (alt_fall)
    );

    // edge source and edge kind, demodulation only
    wire src_rise = in_sel ? alt_rise : cmp_rise;   // see R6
    wire src_fall = in_sel ? alt_fall : cmp_fall;   // see R6
    wire cap_rise = mode_demod & src_rise &
                    ((func == `IRCT_EDGE_RISE) | (func == `IRCT_EDGE_BOTH));  // see R8
    wire cap_fall = mode_demod & src_fall &
                    ((func == `IRCT_EDGE_FALL) | (func == `IRCT_EDGE_BOTH));  // see R8
    wire timeout  = cnt_en & tick & (short_counter == 8'h00);

    // tick divider; counting at a slower rate keeps capture bytes meaningful
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prescale_count <= 8'h00;
            tick           <= 1'b0;
        end else if (prescale_count == PRESCALE[7:0] - 8'd1) begin
            prescale_count <= 8'h00;
            tick           <= 1'b1;
        end else begin
            prescale_count <= prescale_count + 8'd1;
            tick           <= 1'b0;
        end
    end

    // short counter: capture reload wins over tick, zero reloads all ones in demod, load value in transmit
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            short_counter     <= `IRCT_COUNT_RELOAD;
            short_counter_out <= 1'b0;
        end else if (!cnt_en) begin
            short_counter     <= mode_demod ? `IRCT_COUNT_RELOAD : load_value;
        end else if (cap_rise | cap_fall) begin
            short_counter     <= `IRCT_COUNT_RELOAD;   // see R10
        end else if (tick) begin
            if (short_counter == 8'h00) begin
                short_counter     <= mode_demod ? `IRCT_COUNT_RELOAD : load_value;  // see R11
                short_counter_out <= ~short_counter_out;
            end else begin
                short_counter     <= short_counter - 8'd1;
            end
        end
    end

    // capture bytes take the running count on the chosen edge
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rise_capture_byte <= 8'h00;
            fall_capture_byte <= 8'h00;
        end else begin
            if (cap_rise)
                rise_capture_byte <= short_counter;
            if (cap_fall)
                fall_capture_byte <= short_counter;
        end
    end

    // control registers; hardware flag sets win over a software clear
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shared_timer_control  <= `IRCT_SHARED_RESET;   // see R4
            short_counter_control <= `IRCT_SHORT_RESET;
            load_value            <= `IRCT_LOAD_RESET;
        end else begin
            if (apb_write && paddr_in == `IRCT_ADDR_SHARED_CTRL) begin
                // flags clear by writing one to them
                shared_timer_control[7:2] <= pwdata_in[7:2];
                shared_timer_control[1:0] <= shared_timer_control[1:0] & ~pwdata_in[1:0];
            end
            if (apb_write && paddr_in == `IRCT_ADDR_SHORT_CTRL) begin
                short_counter_control <= {pwdata_in[7:6],
                    short_counter_control[`IRCT_KC_TIMEOUT_FLAG] & ~pwdata_in[5],
                    pwdata_in[4:0]};
            end
            if (apb_write && paddr_in == `IRCT_ADDR_LOAD)
                load_value <= pwdata_in[7:0];
            if (cap_rise)
                shared_timer_control[`IRCT_SC_RISE_FLAG] <= 1'b1;   // see R9
            if (cap_fall)
                shared_timer_control[`IRCT_SC_FALL_FLAG] <= 1'b1;   // see R9
            if (timeout)
                short_counter_control[`IRCT_KC_TIMEOUT_FLAG] <= 1'b1;  // see R11
        end
    end

    // interrupt: flag and mask both required
    wire cap_flag = shared_timer_control[`IRCT_SC_RISE_FLAG] |
                    shared_timer_control[`IRCT_SC_FALL_FLAG];
    wire next_irq = (cap_flag & short_counter_control[`IRCT_KC_CAP_MASK]) |   // see R1 R12
                    (short_counter_control[`IRCT_KC_TIMEOUT_FLAG] &
                     short_counter_control[`IRCT_KC_CNT_MASK]);                 // see R2 R12

    // combine the two counter outputs in transmit mode
    reg combined;
    always @* begin
        case (func)                                   // see R7
            `IRCT_LOGIC_AND: combined = short_counter_out & long_counter_out_in;
            `IRCT_LOGIC_OR:  combined = short_counter_out | long_counter_out_in;
            `IRCT_LOGIC_NOR: combined = ~(short_counter_out | long_counter_out_in);
            default:         combined = ~(short_counter_out & long_counter_out_in);
        endcase
    end

    // registered pin and interrupt outputs
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            short_counter_out_pin_out <= 1'b0;
            shared_out_pin_out        <= 1'b0;
            irq_out                   <= 1'b0;
        end else begin
            short_counter_out_pin_out <= short_counter_control[`IRCT_KC_OUT_SEL] ?
                                         short_counter_out : port_out_value_in;   // see R3
            // demod mode leaves the shared pin as ordinary port output
            shared_out_pin_out <= (!mode_demod && in_sel) ?
                                  combined : shared_port_value_in;                // see R5
            irq_out <= next_irq;
        end
    end

    // read data is latched at the end of the setup cycle and stands through the access;
    // a flag set between those two edges shows up on the next read, not this one
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in) begin
            case (paddr_in)
                `IRCT_ADDR_SHARED_CTRL: prdata_out <= {24'h00_0000, shared_timer_control};
                `IRCT_ADDR_SHORT_CTRL:  prdata_out <= {24'h00_0000, short_counter_control};
                `IRCT_ADDR_LOAD:        prdata_out <= {24'h00_0000, load_value};
                `IRCT_ADDR_CAPTURE:     prdata_out <= {16'h0000, fall_capture_byte,
                                                       rise_capture_byte};
                `IRCT_ADDR_STATUS:      prdata_out <= {24'h00_0000, short_counter};
                default:                prdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== verif/irct_props.sv
// port checker for the counter/timer common control
`timescale 1ns/10ps
module irct_props (
    input wire        clk_in,
    input wire        rst_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [7:0]  paddr_in,
    input wire [31:0] pwdata_in,
    input wire        pready_out,
    input wire [31:0] prdata_out,
    input wire        pslverr_out,
    input wire        port_out_value_in,
    input wire        shared_port_value_in,
    input wire        short_counter_out_pin_out,
    input wire        shared_out_pin_out,
    input wire        irq_out
);
    reg  [3:0] ctl;  // mirror of mode, select, function
    reg  [2:0] kc;   // mirror of masks and short select
    wire       acc = psel_in && penable_in && pready_out;
    wire       rd4 = acc && !pwrite_in && paddr_in == 8'h04;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // mirrors move only on a completed write
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl <= 4'h0;
            kc <= 3'h0;
        end else if (acc && pwrite_in && paddr_in == 8'h04) begin
            ctl <= pwdata_in[7:4];
        end else if (acc && pwrite_in && paddr_in == 8'h08) begin
            kc <= pwdata_in[2:0];
        end
    end
    a_ctl_readback: assert property (rd4 |-> prdata_out[7:4] == ctl)
        else $error("shared control readback differs");
    a_kc_readback: assert property (acc && !pwrite_in && paddr_in == 8'h08
        |-> prdata_out[2:0] == kc) else $error("short control readback differs");
    a_short_port: assert property (!$past(rst_in) && !$past(kc[0])
        |-> short_counter_out_pin_out == $past(port_out_value_in)) else $error("short pin");
    a_xmit_port: assert property (!$past(rst_in) && $past(ctl[3:2]) == 2'b00
        |-> shared_out_pin_out == $past(shared_port_value_in)) else $error("shared pin");
    a_demod_port: assert property (!$past(rst_in) && $past(ctl[3])
        |-> shared_out_pin_out == $past(shared_port_value_in)) else $error("demod pin");
    a_irq_masked: assert property (irq_out |-> $past(kc[2]) || $past(kc[1]))
        else $error("irq without mask");
    a_mask_clear: assert property (acc && pwrite_in && paddr_in == 8'h08
        && pwdata_in[2:1] == 2'b00 |-> ##2 !irq_out) else $error("irq after unmask");
    a_unmapped_err: assert property (acc && paddr_in[1:0] == 2'b00
        && (paddr_in < 8'h04 || paddr_in > 8'h14) |-> pslverr_out) else $error("no error");
    c_demod: cover property (rd4 && ctl[3]);
    c_irq: cover property ($rose(irq_out));
    c_comb: cover property (ctl[3:2] == 2'b01 && shared_out_pin_out);
endmodule
bind irct_common_ctrl irct_props i_props (.*);

// ===== verif/irct_pin_model.sv
// far-side model of the two edge source pins
`timescale 1ns/10ps
module irct_pin_model (
    input  wire clk_in,    // core clock
    input  wire go_in,     // one-cycle request to flip a pin
    input  wire which_in,  // 0 comparator pin, 1 alternate pin
    output reg  comp_out,  // comparator input pin
    output reg  alt_out    // alternate input pin
);
    // the source always drives its pins, so they idle low, never float
    initial begin
        comp_out = 1'b0;
        alt_out = 1'b0;
    end
    // flip one pin; requests come far apart so each level stands long
    always @(posedge clk_in) begin
        if (go_in && which_in)
            alt_out <= ~alt_out;
        else if (go_in)
            comp_out <= ~comp_out;
    end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the counter/timer common control
`timescale 1ns/10ps
module tb_top;
    reg         clk_in, rst_in, psel, pen, pwr, go, which, port_v, shr_v, long_v, err;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, q;
    wire [31:0] prdata;
    wire        pready, pslverr, short_pin, shared_pin, irq, comp, alt;
    integer     mismatches, cmp_count, seed, cyc, i, j, n;
    irct_common_ctrl #(.PRESCALE(2)) i_irct_common_ctrl (.clk_in(clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
        .comparator_input_pin_in(comp), .alternate_input_pin_in(alt),
        .port_out_value_in(port_v), .shared_port_value_in(shr_v), .long_counter_out_in(long_v),
        .short_counter_out_pin_out(short_pin), .shared_out_pin_out(shared_pin), .irq_out(irq));
    irct_pin_model i_irct_pin_model (.clk_in(clk_in), .go_in(go), .which_in(which),
        .comp_out(comp), .alt_out(alt));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // cut a hang short
    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    // one apb transfer; the idle edge first keeps psel from two writes at once
    task apb(input reg wr, input reg [7:0] a, input reg [31:0] d);
        begin
            @(posedge clk_in);
            psel <= 1'b1;
            pwr <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_in);
            pen <= 1'b1;
            @(posedge clk_in);
            while (pready !== 1'b1)
                @(posedge clk_in);
            q = prdata;
            err = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task chk(input string nm, input reg [31:0] e, input reg [31:0] s);
        begin
            cmp_count = cmp_count + 1;
            if (s !== e) begin
                mismatches = mismatches + 1;
                $display("unexpected %0s exp %h seen %h", nm, e, s);
            end
        end
    endtask
    // flip one pin, then let synchroniser, flag and irq settle
    task pulse(input reg w);
        begin
            which <= w;
            go <= 1'b1;
            @(posedge clk_in);
            go <= 1'b0;
            repeat (8) @(posedge clk_in);
        end
    endtask
    // reference for the transmit combine codes
    function comb(input reg [1:0] c, input reg a, input reg b);
        case (c)
            2'b00: comb = a & b;
            2'b01: comb = a | b;
            2'b10: comb = ~(a | b);
            default: comb = ~(a & b);
        endcase
    endfunction
    task summarize;
        begin
            $display("checks %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        {rst_in, psel, pen, pwr, go, which, port_v, shr_v, long_v} = 9'h100;
        paddr = 8'h00;
        pwdata = 32'h0;
        {seed, mismatches, cmp_count, cyc} = {32'd15, 96'h0};
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        apb(1'b0, 8'h04, 32'h0);
        chk("ctl", 32'h0, q);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h1, {q[31:1], err});
        for (i = 0; i < 4; i = i + 1) begin
            n = $random(seed);
            port_v <= n[0];
            shr_v <= n[1];
            repeat (2) @(posedge clk_in);
            chk("short", port_v, short_pin);
            chk("shared", shr_v, shared_pin);
        end
        $display("port paths done");
        apb(1'b1, 8'h08, 32'h1);
        for (i = 0; i < 8; i = i + 1) begin
            apb(1'b1, 8'h04, {24'h0, 2'b01, i[1:0], 4'h0});
            long_v <= i[2];
            repeat (2) @(posedge clk_in);
            chk("comb", comb(i[1:0], 1'b0, i[2]), shared_pin);
            chk("short", 32'h0, short_pin);
        end
        $display("combine done");
        for (i = 0; i < 6; i = i + 1) begin
            j = i % 3;
            apb(1'b1, 8'h08, i < 3 ? 32'h84 : 32'h80);
            apb(1'b1, 8'h04, {24'h0, 1'b1, i >= 3, j[1:0], 4'h3});
            pulse(i < 3);
            pulse(i < 3);
            apb(1'b0, 8'h04, 32'h0);
            chk("quiet", 32'h0, q[1:0]);
            pulse(i >= 3);
            pulse(i >= 3);
            apb(1'b0, 8'h04, 32'h0);
            chk("flags", {j != 0, j != 1}, q[1:0]);
            chk("irq", i < 3, irq);
            // a capture reloaded all ones a few ticks ago, so the count is still high
            apb(1'b0, 8'h14, 32'h0);
            chk("reload", 32'h1, q[7:0] >= 8'hF0);
        end
        $display("capture done");
        apb(1'b1, 8'h08, 32'hA2);
        n = 0;
        while (irq !== 1'b1 && n < 600) begin
            @(posedge clk_in);
            n = n + 1;
        end
        chk("tmo irq", 32'h1, irq);
        apb(1'b0, 8'h08, 32'h0);
        chk("tmo flag", 32'h1, q[5]);
        apb(1'b1, 8'h08, 32'h20);
        repeat (2) @(posedge clk_in);
        chk("tmo off", 32'h0, irq);
        $display("timeout done");
        // transmit: short pin follows the counter, half period is load plus one ticks
        apb(1'b1, 8'h0C, 32'h3);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h81);
        repeat (20) @(posedge clk_in);
        for (i = 0; i < 4; i = i + 1) begin
            j = short_pin;
            repeat ((3 + 1) * 2) @(posedge clk_in);
            chk("toggle", {31'h0, ~j[0]}, short_pin);
        end
        $display("toggle done");
        summarize;
    end
endmodule
